// file: sacq_pkg.sv
// Purpose: constants and types for the scan acquisition controller
// Assumes: APB register map, one aligned 32-bit word per register
// Notes:   channel list entry = act, last, timer select, channel id
//
// Overview of operation
// - Eight sixteen-bit programmable sample-rate timers
// - Each channel assigned to one timer
// - External trigger edge selectable rising or falling
// - Software picks internal timers or external trigger
// - Gate passes external events only while asserted
// - Software picks external or internal gate source
// - Channel list held in 2 KB memory
// - Scanner idles until triggered, then walks list
// - Strobe sample-and-hold on every scan event
// - One convert trigger for all channels
// - Read active channels, store results sequentially
// - Results buffered in up to 6 MB memory
package sacq_pkg;

  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_WPTR = 8'h08;
  localparam logic [7:0] A_CADR = 8'h0C;
  localparam logic [7:0] A_CDAT = 8'h10;
  localparam logic [7:0] A_TMR0 = 8'h20;

  // Control bit positions
  localparam int C_RUN  = 0;
  localparam int C_TEXT = 1;
  localparam int C_FALL = 2;
  localparam int C_GEXT = 3;
  localparam int C_GINT = 4;
  localparam int C_GEN  = 5;
  localparam int C_W    = 6;

  // Channel list entry fields
  localparam int E_ACT  = 15;
  localparam int E_LAST = 14;
  localparam int E_TSEL = 8;
  localparam int E_CHW  = 7;

  // Values after reset
  localparam logic [5:0]  CTRL_RST = 6'h00;
  localparam logic [15:0] TMR_RST  = 16'hFFFF;

  // Scanner states, system side
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_CONV  = 4'b0010,
    S_FETCH = 4'b0100,
    S_CHECK = 4'b1000
  } sacq_st_e;

  // Converter sequencer states, link side
  typedef enum logic [4:0] {
    L_IDLE = 5'b00001,
    L_HOLD = 5'b00010,
    L_CONV = 5'b00100,
    L_WAIT = 5'b01000,
    L_READ = 5'b10000
  } sacq_lk_e;

endpackage

// file: sacq_ctrl.sv
// Purpose: scan acquisition controller, timers, list walker, link
// Assumes: clk_sys 100 MHz, clk_link from converter side, APB slave
// Notes:   buffer memory itself sits outside, dual ported to readers
`timescale 1ns/100ps
module sacq_ctrl #(
  parameter int TMR_N     = 8,
  parameter int TMR_W     = 16,
  parameter int CH_DEPTH  = 1024,
  parameter int BUF_AW    = 22,
  parameter int BUF_WORDS = 3145728
) (
  // System
  input  wire logic              clk_sys,
  input  wire logic              reset,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Differential trigger and gate pins
  input  wire logic              trig_p,
  input  wire logic              trig_n,
  input  wire logic              gate_p,
  input  wire logic              gate_n,
  // Converter link
  input  wire logic              clk_link,
  output logic                   sample_hold_strobe,
  output logic                   adc_convert,
  input  wire logic              adc_conv_done,
  output logic      [6:0]        adc_chan_sel,
  input  wire logic [15:0]       adc_data,
  // Data buffer write port
  output logic                   buf_we,
  output logic      [BUF_AW-1:0] buf_addr,
  output logic      [15:0]       buf_wdata
);

  localparam int CAW = $clog2(CH_DEPTH);
  localparam logic [CAW-1:0]    CP_MAX = CAW'(CH_DEPTH - 1);
  localparam logic [BUF_AW-1:0] WP_MAX = BUF_AW'(BUF_WORDS - 1);

  // Registers, system side
  logic [5:0]        ctrl_r;
  logic [TMR_W-1:0]  tmr_r [TMR_N];
  logic [TMR_W-1:0]  cnt_r [TMR_N];
  logic [15:0]       chan_mem [CH_DEPTH];
  logic [CAW-1:0]    cadr_r;
  logic [BUF_AW-1:0] wptr_r;
  logic [31:0]       prdata_r;
  logic              perr_r;
  logic [3:0]        ext_s1_r;
  logic [3:0]        ext_s2_r;
  logic              trig_d_r;
  logic [TMR_N-1:0]  pend_r;
  logic [TMR_N-1:0]  pend_nxt;
  logic [TMR_N-1:0]  mask_r;
  sacq_pkg::sacq_st_e st_r;
  logic [CAW-1:0]    cp_r;
  logic [15:0]       ent_r;
  logic              busy_r;
  logic              scan_tgl_r;
  logic              rd_tgl_r;
  logic [6:0]        rd_chan_r;
  logic [2:0]        cack_s_r;
  logic [2:0]        rack_s_r;
  logic              rwait_r;
  logic              we_r;
  logic [BUF_AW-1:0] addr_r;
  logic [15:0]       wdat_r;

  // Registers, link side
  logic              lrst1_r;
  logic              lrst_r;
  logic [2:0]        scan_s_r;
  logic [2:0]        rd_s_r;
  logic              lrd_r;
  sacq_pkg::sacq_lk_e lst_r;
  logic              sh_r;
  logic              cv_r;
  logic [6:0]        sel_r;
  logic [15:0]       ldat_r;
  logic              cack_tgl_r;
  logic              rack_tgl_r;

  // APB decode
  wire         setup_w = psel & ~penable;
  wire         wr_w    = psel & penable & pwrite;
  wire         tmr_hit = paddr[7:5] == sacq_pkg::A_TMR0[7:5];
  wire [2:0]   tsel_w  = paddr[4:2];
  wire         map_w   = (paddr == sacq_pkg::A_CTRL) |
                         (paddr == sacq_pkg::A_STAT) |
                         (paddr == sacq_pkg::A_WPTR) |
                         (paddr == sacq_pkg::A_CADR) |
                         (paddr == sacq_pkg::A_CDAT) | tmr_hit;
  wire [15:0]  cdat_rd = chan_mem[cadr_r];
  wire [31:0]  rd_mux  =
    (paddr == sacq_pkg::A_CTRL) ? {26'h000_0000, ctrl_r} :
    (paddr == sacq_pkg::A_STAT) ? {16'h0000, mask_r, pend_r[7:0]}
      | {31'h0000_0000, busy_r} << 31 :
    (paddr == sacq_pkg::A_WPTR) ? 32'(wptr_r) :
    (paddr == sacq_pkg::A_CADR) ? 32'(cadr_r) :
    (paddr == sacq_pkg::A_CDAT) ? {16'h0000, cdat_rd} :
    tmr_hit ? {16'h0000, tmr_r[tsel_w]} : 32'h0000_0000;

  // Zero-wait slave: data latched in setup, ready in access
  assign pready  = psel & penable;
  assign prdata  = prdata_r;
  assign pslverr = perr_r & psel & penable;

  // Read data and error flag captured during setup
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prdata_r <= 32'h0000_0000;
      perr_r   <= 1'b0;
    end else if (setup_w) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      perr_r   <= ~map_w;
    end
  end

  // Control, timer reload and list address registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_r <= sacq_pkg::CTRL_RST;
      cadr_r <= '0;
      for (int i = 0; i < TMR_N; i++) tmr_r[i] <= sacq_pkg::TMR_RST;
    end else if (wr_w) begin
      if (paddr == sacq_pkg::A_CTRL)
        ctrl_r <= pwdata[sacq_pkg::C_W-1:0];
      if (paddr == sacq_pkg::A_CADR)
        cadr_r <= pwdata[CAW-1:0];
      if (paddr == sacq_pkg::A_CDAT)
        cadr_r <= cadr_r + 1'b1; // Auto-increment for fast list load
      if (tmr_hit)
        tmr_r[tsel_w] <= pwdata[TMR_W-1:0];
    end
  end

  // Channel list memory, written by software only
  always_ff @(posedge clk_sys) begin
    if (wr_w && paddr == sacq_pkg::A_CDAT)
      chan_mem[cadr_r] <= pwdata[15:0];
  end

  // Entry fetch, always tracks walker pointer
  always_ff @(posedge clk_sys) begin
    ent_r <= chan_mem[cp_r];
  end

  // Pin synchronisers and trigger edge history
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ext_s1_r <= 4'h0;
      ext_s2_r <= 4'h0;
      trig_d_r <= 1'b0;
    end else begin
      ext_s1_r <= {gate_n, gate_p, trig_n, trig_p};
      ext_s2_r <= ext_s1_r;
      trig_d_r <= ext_s2_r[0] & ~ext_s2_r[1];
    end
  end

  // Differential levels, edge pick and gating
  wire trig_lv = ext_s2_r[0] & ~ext_s2_r[1];
  wire gate_lv = ext_s2_r[2] & ~ext_s2_r[3];
  wire edge_w  = ctrl_r[sacq_pkg::C_FALL] ? (trig_d_r & ~trig_lv)
                                          : (trig_lv & ~trig_d_r);
  wire gsrc_w  = ctrl_r[sacq_pkg::C_GEXT] ? gate_lv
                                          : ctrl_r[sacq_pkg::C_GINT];
  wire gate_w  = ~ctrl_r[sacq_pkg::C_GEN] | gsrc_w;
  wire run_w   = ctrl_r[sacq_pkg::C_RUN];
  wire ext_ev  = run_w & ctrl_r[sacq_pkg::C_TEXT] & edge_w & gate_w;
  wire int_en  = run_w & ~ctrl_r[sacq_pkg::C_TEXT];

  // Timer tick decode, one per timer
  logic [TMR_N-1:0] tick_w;
  for (genvar g = 0; g < TMR_N; g++) begin : g_tick
    assign tick_w[g] = int_en & (cnt_r[g] == '0);
  end

  // Down-counters reload on zero; held loaded while stopped
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < TMR_N; i++) begin
      if (reset)
        cnt_r[i] <= sacq_pkg::TMR_RST;
      else if (!int_en || cnt_r[i] == '0)
        cnt_r[i] <= tmr_r[i];
      else
        cnt_r[i] <= cnt_r[i] - 1'b1;
    end
  end

  // Pending events; a new tick wins over the clear at start
  wire start_w = (st_r == sacq_pkg::S_IDLE) & (|pend_r);
  assign pend_nxt = (start_w ? '0 : pend_r) | tick_w
                  | {TMR_N{ext_ev}};

  // Handshake toggles back from link side
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cack_s_r <= 3'h0;
      rack_s_r <= 3'h0;
    end else begin
      cack_s_r <= {cack_s_r[1:0], cack_tgl_r};
      rack_s_r <= {rack_s_r[1:0], rack_tgl_r};
    end
  end
  wire cack_w = cack_s_r[2] ^ cack_s_r[1];
  wire rack_w = rack_s_r[2] ^ rack_s_r[1];

  // Entry qualification against the scan's timer mask
  wire [2:0] etsel_w = ent_r[sacq_pkg::E_TSEL +: 3];
  wire       qual_w  = ent_r[sacq_pkg::E_ACT] & mask_r[etsel_w];
  wire       end_w   = ent_r[sacq_pkg::E_LAST] | (cp_r == CP_MAX);
  // Step on when a read came back or the entry is skipped
  wire       adv_w   = rwait_r ? rack_w : ~qual_w;

  // Buffer write port and link pins straight from flops
  assign buf_we             = we_r;
  assign buf_addr           = addr_r;
  assign buf_wdata          = wdat_r;
  assign sample_hold_strobe = sh_r;
  assign adc_convert        = cv_r;
  assign adc_chan_sel       = sel_r;

  // List walker: idle, convert, fetch, check and read
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_r       <= sacq_pkg::S_IDLE;
      pend_r     <= '0;
      mask_r     <= '0;
      cp_r       <= '0;
      busy_r     <= 1'b0;
      scan_tgl_r <= 1'b0;
      rd_tgl_r   <= 1'b0;
      rd_chan_r  <= 7'h00;
      rwait_r    <= 1'b0;
      we_r       <= 1'b0;
      addr_r     <= '0;
      wdat_r     <= 16'h0000;
      wptr_r     <= '0;
    end else begin
      pend_r <= pend_nxt;
      we_r   <= 1'b0;
      case (st_r)
        sacq_pkg::S_IDLE: begin
          if (start_w) begin
            mask_r     <= pend_r;
            scan_tgl_r <= ~scan_tgl_r;
            busy_r     <= 1'b1;
            st_r       <= sacq_pkg::S_CONV;
          end
        end
        sacq_pkg::S_CONV: begin
          if (cack_w) begin
            cp_r <= '0;
            st_r <= sacq_pkg::S_FETCH;
          end
        end
        sacq_pkg::S_FETCH: st_r <= sacq_pkg::S_CHECK;
        sacq_pkg::S_CHECK: begin
          // Only one read in flight; link data holds until rack
          if (!rwait_r && qual_w) begin
            rd_chan_r <= ent_r[6:0];
            rd_tgl_r  <= ~rd_tgl_r;
            rwait_r   <= 1'b1;
          end
          if (rwait_r && rack_w) begin
            rwait_r <= 1'b0;
            we_r    <= 1'b1;
            addr_r  <= wptr_r;
            wdat_r  <= ldat_r;
            wptr_r  <= (wptr_r == WP_MAX) ? '0 : wptr_r + 1'b1;
          end
          if (adv_w) begin
            if (end_w) begin
              busy_r <= 1'b0;
              st_r   <= sacq_pkg::S_IDLE;
            end else begin
              cp_r <= cp_r + 1'b1;
              st_r <= sacq_pkg::S_FETCH;
            end
          end
        end
        default: st_r <= sacq_pkg::S_IDLE;
      endcase
    end
  end

  // Link reset and toggle synchronisers; toggles cross, not pulses
  always_ff @(posedge clk_link) begin
    lrst1_r <= reset;
    lrst_r  <= lrst1_r;
    if (lrst_r) begin
      scan_s_r <= 3'h0;
      rd_s_r   <= 3'h0;
    end else begin
      scan_s_r <= {scan_s_r[1:0], scan_tgl_r};
      rd_s_r   <= {rd_s_r[1:0], rd_tgl_r};
    end
  end
  wire scan_ev = scan_s_r[2] ^ scan_s_r[1];
  wire rd_ev   = rd_s_r[2] ^ rd_s_r[1];

  // Converter sequencer: hold, convert, wait, then serve reads
  always_ff @(posedge clk_link) begin
    if (lrst_r) begin
      lst_r      <= sacq_pkg::L_IDLE;
      sh_r       <= 1'b0;
      cv_r       <= 1'b0;
      sel_r      <= 7'h00;
      ldat_r     <= 16'h0000;
      cack_tgl_r <= 1'b0;
      rack_tgl_r <= 1'b0;
      lrd_r      <= 1'b0;
    end else begin
      sh_r <= 1'b0;
      cv_r <= 1'b0;
      case (lst_r)
        sacq_pkg::L_IDLE: begin
          if (scan_ev) begin
            sh_r  <= 1'b1;
            lst_r <= sacq_pkg::L_HOLD;
          end
        end
        sacq_pkg::L_HOLD: begin
          cv_r  <= 1'b1;
          lst_r <= sacq_pkg::L_CONV;
        end
        sacq_pkg::L_CONV: lst_r <= sacq_pkg::L_WAIT;
        sacq_pkg::L_WAIT: begin
          // Done was cleared by the strobe, so no stale level here
          if (adc_conv_done) begin
            cack_tgl_r <= ~cack_tgl_r;
            lst_r      <= sacq_pkg::L_READ;
          end
        end
        sacq_pkg::L_READ: begin
          if (lrd_r) begin
            ldat_r     <= adc_data;
            rack_tgl_r <= ~rack_tgl_r;
            lrd_r      <= 1'b0;
          end else if (rd_ev) begin
            sel_r <= rd_chan_r;
            lrd_r <= 1'b1;
          end else if (scan_ev) begin
            sh_r  <= 1'b1;
            lst_r <= sacq_pkg::L_HOLD;
          end
        end
        default: lst_r <= sacq_pkg::L_IDLE;
      endcase
    end
  end

endmodule

// file: sacq_ctrl_chk.sv
// Purpose: port checker for the scan controller
// Assumes: one reset serves both clock domains
// Notes:   bound below the module
`timescale 1ns/100ps
module sacq_ctrl_chk #(parameter int BUF_AW = 22) (
  // System and APB
  input wire logic              clk_sys,
  input wire logic              reset,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  // Link
  input wire logic              clk_link,
  input wire logic              sample_hold_strobe,
  input wire logic              adc_convert,
  // Buffer
  input wire logic              buf_we,
  input wire logic [BUF_AW-1:0] buf_addr
);
  logic [BUF_AW-1:0] last_r;
  logic              seen_r;
  // Last stored word, so each step can be checked
  always_ff @(posedge clk_sys) begin
    if (reset) seen_r <= 1'b0;
    else if (buf_we) seen_r <= 1'b1;
    if (buf_we) last_r <= buf_addr;
  end
  a_ptr_home: assert property (@(posedge clk_sys)
    $fell(reset) |-> buf_addr == '0) else $error("pointer off start");
  a_first_word: assert property (@(posedge clk_sys) disable iff (reset)
    buf_we && !seen_r |-> buf_addr == '0) else $error("first word off");
  a_ptr_step: assert property (@(posedge clk_sys) disable iff (reset)
    buf_we && seen_r |-> buf_addr == last_r + 1'b1) else $error("bad step");
  a_idle_quiet: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(reset) |-> !buf_we [*8]) else $error("store while idle");
  a_apb_answer: assert property (@(posedge clk_sys) disable iff (reset)
    psel && penable |-> ##[0:15] pready) else $error("no pready");
  a_hold_conv: assert property (@(posedge clk_link) disable iff (reset)
    $rose(sample_hold_strobe) |-> ##[0:16] adc_convert) else $error("no conv");
  a_hold_short: assert property (@(posedge clk_link) disable iff (reset)
    sample_hold_strobe |-> ##[1:8] !sample_hold_strobe) else $error("stuck");
  a_store_after: assert property (@(posedge clk_sys) disable iff (reset)
    buf_we |-> !adc_convert) else $error("store during convert");
  c_store: cover property (@(posedge clk_sys) buf_we);
  c_conv: cover property (@(posedge clk_link) $rose(adc_convert));
  c_apb: cover property (@(posedge clk_sys) psel && penable && pready);
endmodule
bind sacq_ctrl sacq_ctrl_chk #(.BUF_AW(BUF_AW)) i_sacq_ctrl_chk (
  .clk_sys, .reset, .psel, .penable, .pready, .clk_link,
  .sample_hold_strobe, .adc_convert, .buf_we, .buf_addr);

// file: sacq_adc_model.sv
// Purpose: converter card stand-in on the link clock
// Assumes: result valid from done until the next strobe
// Notes:   data outside that span is scrambled on purpose
`timescale 1ns/100ps
module sacq_adc_model #(parameter int CONV_CYC = 3) (
  // Link
  input  wire logic        clk_link,
  input  wire logic        sample_hold_strobe,
  input  wire logic        adc_convert,
  output logic             adc_conv_done,
  // Readout
  input  wire logic [6:0]  adc_chan_sel,
  output logic      [15:0] adc_data
);
  logic [2:0] cnt_r = 3'h0;
  logic       done_r = 1'b0;
  // All inputs held at once, one trigger converts all
  always @(posedge clk_link) begin
    if (sample_hold_strobe) done_r <= 1'b0;
    if (adc_convert) cnt_r <= 3'(CONV_CYC);
    else if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
    if (cnt_r == 3'h1) done_r <= 1'b1;
  end
  assign adc_conv_done = done_r;
  // Negative word tagged by channel, never a stale copy
  assign adc_data = done_r ? {9'h1FF, adc_chan_sel}
                           : {9'h0A5, ~adc_chan_sel};
endmodule

// file: sacq_ctrl_tb_top.sv
// Purpose: self-checking bench for the scan controller
// Assumes: converter model on the link side
// Notes:   each trial resets, so the buffer starts at word zero
`timescale 1ns/100ps
module sacq_ctrl_tb_top;
  logic        clk_sys, clk_link, reset, psel, penable, pwrite;
  logic        pready, pslverr, trig_p, trig_n, gate_p, gate_n, er;
  logic        sample_hold_strobe, adc_convert, adc_conv_done, buf_we;
  logic [7:0]  paddr;
  logic [6:0]  adc_chan_sel;
  logic [15:0] adc_data, buf_wdata, lst [3], tr [7];
  logic [21:0] buf_addr;
  logic [31:0] pwdata, prdata, rd;
  logic [37:0] wq [$];
  int          failures, checks, n1;
  sacq_ctrl i_sacq_ctrl (.clk_sys, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .trig_p, .trig_n,
    .gate_p, .gate_n, .clk_link, .sample_hold_strobe, .adc_convert,
    .adc_conv_done, .adc_chan_sel, .adc_data, .buf_we, .buf_addr,
    .buf_wdata);
  sacq_adc_model i_sacq_adc_model (.clk_link, .sample_hold_strobe,
    .adc_convert, .adc_conv_done, .adc_chan_sel, .adc_data);
  // Clocks, link offset in phase
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #3.3;
    forever #40 clk_link = ~clk_link;
  end
  // Log every buffer write
  always @(posedge clk_sys) if (buf_we) wq.push_back({buf_addr, buf_wdata});
  // Request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic chk(input logic [37:0] got, input logic [37:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic do_reset;
    reset <= 1'b1;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    wq.delete();
  endtask
  task automatic load_list;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, sacq_pkg::A_CADR, 32'(i));
      apb(1'b1, sacq_pkg::A_CDAT, {16'h0, lst[i]});
      apb(1'b1, sacq_pkg::A_CADR, 32'(i));
      apb(1'b0, sacq_pkg::A_CDAT, 32'h0);
      chk({6'h0, rd}, {22'h0, lst[i]});
    end
  endtask
  task automatic trig(input logic v);
    trig_p <= v;
    trig_n <= ~v;
    repeat (400) @(posedge clk_sys);
  endtask
  // Code: control in the top byte, gate in bit 4, rise/fall expected
  task automatic trial(input logic [15:0] t);
    do_reset;
    load_list;
    gate_p <= t[4];
    gate_n <= ~t[4];
    apb(1'b1, sacq_pkg::A_CTRL, {24'h0, t[15:8]});
    trig(1'b1);
    n1 = wq.size();
    trig(1'b0);
    chk({36'h0, n1 != 0, wq.size() > n1}, {36'h0, t[1:0]});
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #500_000;
    failures++;
    close_out;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {trig_p, gate_p, reset, trig_n, gate_n} = 5'b0_0111;
    lst = '{16'h8105, 16'h0106, 16'hC109};
    tr = '{16'h0302, 16'h0701, 16'h2B00, 16'h2B12, 16'h3302, 16'h2310,
           16'h0100};
    failures = 0;
    checks = 0;
    do_reset;
    apb(1'b0, sacq_pkg::A_CTRL, 32'h0);
    chk({5'h0, er, rd}, {32'h0, sacq_pkg::CTRL_RST});
    // Reset value, then eight distinct divisors read back
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, sacq_pkg::A_TMR0 + 8'(4 * (i % 8)), 32'h0);
      if (i < 8) chk({6'h0, rd}, {22'h0, sacq_pkg::TMR_RST});
      else chk({6'h0, rd}, {22'h0, 16'h8000 + 16'(i - 8)});
      if (i < 8) apb(1'b1, sacq_pkg::A_TMR0 + 8'(4 * i), 32'h8000 + i);
    end
    // Only timer one paces the listed channels
    do_reset;
    load_list;
    apb(1'b1, sacq_pkg::A_TMR0 + 8'h04, 32'h0000_0200);
    apb(1'b1, sacq_pkg::A_CTRL, 32'h0000_0001);
    repeat (1500) @(posedge clk_sys);
    chk(wq[0], {22'h0, 16'hFF85});
    chk(wq[1], {22'h1, 16'hFF89});
    for (int i = 0; i < 7; i++) trial(tr[i]);
    close_out;
  end
endmodule
